// ---- include/dmi_pkg.sv ----
// shared constants for the data mask and bus inversion lane logic
package dmi_pkg;

    // ------------------------------------------------------------
    // mode register layout
    // ------------------------------------------------------------
    localparam int MR_W         = 14;
    localparam int MR1_TERMINATION_STROBE_BIT = 11;
    localparam int MR5_WMASK_BIT = 10;
    localparam int MR5_WINV_BIT = 11;
    localparam int MR5_RINV_BIT = 12;

    // ------------------------------------------------------------
    // device widths and lane geometry
    // ------------------------------------------------------------
    localparam int WIDTH_NIBBLE = 4;
    localparam int WIDTH_BYTE   = 8;
    localparam int WIDTH_WORD   = 16;

    // read inversion fires above this many zero bits in a lane
    localparam int DBI_ZERO_LIMIT = 4;

    // ------------------------------------------------------------
    // buffering
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_STAGES = 3;

endpackage : dmi_pkg

// ---- include/word_if.sv ----
// valid/ready word carrier between the lane logic and its buffer
`timescale 1ns/100ps
interface word_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    // producer side
    modport src (output valid, output data, input ready);
    // consumer side
    modport dst (input valid, input data, output ready);
endinterface : word_if

// ---- src/bit_sync.sv ----
// multi-flop synchroniser for levels and gray-coded pointers
`timescale 1ns/100ps
module bit_sync #(
    parameter int W      = 1,
    parameter int STAGES = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [STAGES-1:0][W-1:0] s;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // shift chain; only the last stage is read outside
    always_comb begin
        st_nxt   = st_r;
        st_nxt.s = {st_r.s[STAGES-2:0], d};
        if (rst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign q = st_r.s[STAGES-1];
endmodule : bit_sync

// ---- src/cdc_fifo.sv ----
// dual-clock fifo with gray-coded pointers
`timescale 1ns/100ps
module cdc_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    input  wire logic wr_clk,
    input  wire logic wr_rst,
    input  wire logic rd_clk,
    input  wire logic rd_rst,
    word_if.dst       push,
    word_if.src       pop
);
    import dmi_pkg::*;
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic        full;
    } wside_t;
    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
    } rside_t;

    logic [W-1:0] mem [DEPTH];
    wside_t       w_r;
    wside_t       w_nxt;
    rside_t       r_r;
    rside_t       r_nxt;
    logic [AW:0]  rgray_w;
    logic [AW:0]  wgray_r;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    // pointers cross by three flops each
    bit_sync #(.W(AW+1), .STAGES(SYNC_STAGES)) u_r2w (
        .clk(wr_clk), .rst(wr_rst), .d(r_r.gray), .q(rgray_w));
    bit_sync #(.W(AW+1), .STAGES(SYNC_STAGES)) u_w2r (
        .clk(rd_clk), .rst(rd_rst), .d(w_r.gray), .q(wgray_r));

    // write side: full is registered, so ready comes from a flop
    always_comb begin
        w_nxt = w_r;
        if (push.valid && !w_r.full) begin
            w_nxt.bin = w_r.bin + 1'b1;
        end
        w_nxt.gray = to_gray(w_nxt.bin);
        w_nxt.full = (w_nxt.gray == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
        if (wr_rst) begin
            w_nxt = '0;
        end
    end

    always_ff @(posedge wr_clk) begin
        w_r <= w_nxt;
        if (push.valid && !w_r.full) begin
            mem[w_r.bin[AW-1:0]] <= push.data;
        end
    end

    assign push.ready = !w_r.full;

    // read side: empty when pointers meet
    always_comb begin
        r_nxt = r_r;
        if (pop.valid && pop.ready) begin
            r_nxt.bin = r_r.bin + 1'b1;
        end
        r_nxt.gray = to_gray(r_nxt.bin);
        if (rd_rst) begin
            r_nxt = '0;
        end
    end

    always_ff @(posedge rd_clk) begin
        r_r <= r_nxt;
    end

    assign pop.valid = (r_r.gray != wgray_r);
    assign pop.data  = mem[r_r.bin[AW-1:0]];
endmodule : cdc_fifo

// ---- src/dram_data_mask_inversion.sv ----
// byte-lane write masking, bus inversion and termination strobe logic
`timescale 1ns/100ps

// What this block does
// - masking and inversion only on x8, x16
// - termination strobe only on x8 devices
// - one shared active-low pin per lane
// - termination strobe never drives the pin
// - both write functions off: receiver off, ignored
// - reads: inversion only; off means pin undriven
// - termination strobe disables mask and both inversions
// - termination strobe pins get data strobe termination
// - mode one bit A11 enables termination strobe
// - mode five A10 mask, A11/A12 inversions
// - mask: pin low discards lane, high writes
// - write inversion: pin low inverts lane data
// - read: over four zeros, invert, pin low
module dram_data_mask_inversion #(
    parameter int DEV_W = dmi_pkg::WIDTH_BYTE,
    parameter int DEPTH = dmi_pkg::FIFO_DEPTH
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  link_clk,
    input  wire logic [dmi_pkg::MR_W-1:0] mode_register_one,
    input  wire logic [dmi_pkg::MR_W-1:0] mode_register_five,
    input  wire logic                  dqs_odt_en,
    input  wire logic                  wr_strobe,
    input  wire logic [DEV_W-1:0]      dq_in,
    input  wire logic [((DEV_W==16)?2:1)-1:0] lane_pin_n_in,
    output logic                       wr_ready,
    input  wire logic                  array_wr_ready,
    output logic                       array_wr_valid,
    output logic [DEV_W-1:0]           array_wr_data,
    output logic [((DEV_W==16)?2:1)-1:0] array_wr_byte_en,
    input  wire logic                  rd_valid,
    input  wire logic [DEV_W-1:0]      rd_data,
    output logic [DEV_W-1:0]           dq_out,
    output logic                       dq_oe,
    output logic [((DEV_W==16)?2:1)-1:0] lane_pin_n_out,
    output logic [((DEV_W==16)?2:1)-1:0] lane_pin_n_oe,
    output logic                       lane_rx_en,
    output logic                       term_strobe_odt
);
    import dmi_pkg::*;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int  LANES    = (DEV_W == WIDTH_WORD) ? 2 : 1;
    localparam int  LW       = DEV_W / LANES;
    localparam int  FW       = DEV_W + LANES;
    localparam bit  HAS_DMI  = (DEV_W != WIDTH_NIBBLE);
    localparam bit  HAS_TERMINATION_STROBE = (DEV_W == WIDTH_BYTE);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic             valid;
        logic [DEV_W-1:0] data;
        logic [LANES-1:0] pin;
    } link_t;

    typedef struct packed {
        logic             wvalid;
        logic [DEV_W-1:0] wdata;
        logic [LANES-1:0] wbe;
        logic [DEV_W-1:0] dq;
        logic             dq_oe;
        logic [LANES-1:0] pin;
        logic [LANES-1:0] pin_oe;
        logic             rx_en;
        logic             odt;
    } ref_t;

    link_t lk_r;
    link_t lk_nxt;
    ref_t  rf_r;
    ref_t  rf_nxt;
    logic  link_rst;
    logic  termination_strobe_on;
    logic  wmask_on;
    logic  winv_on;
    logic  rinv_on;

    word_if #(.W(FW)) push_if ();
    word_if #(.W(FW)) pop_if ();

    // true when a lane holds more zero bits than the limit
    function automatic logic many_zeros(input logic [LW-1:0] b);
        int z;
        z = 0;
        for (int i = 0; i < LW; i++) begin
            if (!b[i]) begin
                z = z + 1;
            end
        end
        return z > DBI_ZERO_LIMIT;
    endfunction : many_zeros

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // termination strobe overrides every lane function
    always_comb begin
        termination_strobe_on  = HAS_TERMINATION_STROBE && mode_register_one[MR1_TERMINATION_STROBE_BIT];
        wmask_on = HAS_DMI && !termination_strobe_on
                   && mode_register_five[MR5_WMASK_BIT];
        // if software sets both, masking is kept
        winv_on  = HAS_DMI && !termination_strobe_on && !wmask_on
                   && mode_register_five[MR5_WINV_BIT];
        rinv_on  = HAS_DMI && !termination_strobe_on
                   && mode_register_five[MR5_RINV_BIT];
    end

    // ------------------------------------------------------------
    // link domain capture
    // ------------------------------------------------------------
    // reset reaches the link side through three flops
    bit_sync #(.W(1), .STAGES(SYNC_STAGES)) u_rst_sync (
        .clk(link_clk),
        .rst(1'b0),
        .d  (srst),
        .q  (link_rst)
    );

    // data and lane pins are sampled on the link's own clock
    always_comb begin
        lk_nxt = lk_r;
        if (lk_r.valid && push_if.ready) begin
            lk_nxt.valid = 1'b0;
        end
        if (wr_strobe && (!lk_r.valid || push_if.ready)) begin
            lk_nxt.valid = 1'b1;
            lk_nxt.data  = dq_in;
            lk_nxt.pin   = lane_pin_n_in;
        end
        if (link_rst) begin
            lk_nxt = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        lk_r <= lk_nxt;
    end

    assign push_if.valid = lk_r.valid;
    assign push_if.data  = {lk_r.pin, lk_r.data};
    assign wr_ready      = push_if.ready;

    // ------------------------------------------------------------
    // clock crossing buffer
    // ------------------------------------------------------------
    cdc_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .wr_clk(link_clk),
        .wr_rst(link_rst),
        .rd_clk(ref_clk),
        .rd_rst(srst),
        .push  (push_if),
        .pop   (pop_if)
    );

    // array stalls back up through the buffer
    assign pop_if.ready = !rf_r.wvalid || array_wr_ready;

    // ------------------------------------------------------------
    // core domain: write decode, read encode, pin control
    // ------------------------------------------------------------
    always_comb begin
        logic [LANES-1:0] pin;
        logic [LW-1:0]    lane;
        pin    = '1;
        lane   = '0;
        rf_nxt = rf_r;
        // receiver only on while a write function uses the pin
        rf_nxt.rx_en = wmask_on || winv_on;
        if (rf_r.wvalid && array_wr_ready) begin
            rf_nxt.wvalid = 1'b0;
        end
        if (pop_if.valid && pop_if.ready) begin
            rf_nxt.wvalid = 1'b1;
            if (rf_r.rx_en) begin
                pin = pop_if.data[FW-1 -: LANES];
            end
            for (int l = 0; l < LANES; l++) begin
                lane = pop_if.data[l*LW +: LW];
                if (winv_on && !pin[l]) begin
                    lane = ~lane;
                end
                rf_nxt.wdata[l*LW +: LW] = lane;
                rf_nxt.wbe[l] = !(wmask_on && !pin[l]);
            end
        end
        // read lanes, each with its own inversion decision
        rf_nxt.dq_oe = rd_valid;
        for (int l = 0; l < LANES; l++) begin
            lane = rd_data[l*LW +: LW];
            rf_nxt.pin[l] = 1'b1;
            if (rinv_on && many_zeros(lane)) begin
                lane = ~lane;
                rf_nxt.pin[l] = 1'b0;
            end
            rf_nxt.dq[l*LW +: LW] = lane;
            // pin driven only for read inversion
            rf_nxt.pin_oe[l] = rd_valid && rinv_on;
        end
        // strobe pair copies the data strobe termination
        rf_nxt.odt = termination_strobe_on && dqs_odt_en;
        if (srst) begin
            rf_nxt     = '0;
            rf_nxt.wbe = '1;
            rf_nxt.pin = '1;
        end
    end

    always_ff @(posedge ref_clk) begin
        rf_r <= rf_nxt;
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign array_wr_valid   = rf_r.wvalid;
    assign array_wr_data    = rf_r.wdata;
    assign array_wr_byte_en = rf_r.wbe;
    assign dq_out           = rf_r.dq;
    assign dq_oe            = rf_r.dq_oe;
    assign lane_pin_n_out   = rf_r.pin;
    assign lane_pin_n_oe    = rf_r.pin_oe;
    assign lane_rx_en       = rf_r.rx_en;
    assign term_strobe_odt  = rf_r.odt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic pop_fire;
    assign pop_fire = pop_if.valid && pop_if.ready;
    // lane pin pattern with only the lowest lane asking
    localparam logic [LANES-1:0] LOW_LANE_ONLY = ~LANES'(1);

    a_nibble_no_pin: assert property (
        !HAS_DMI |-> !lane_rx_en && (lane_pin_n_oe == '0))
        else $error("nibble device touched the lane pin");

    a_strobe_x8_only: assert property (
        !HAS_TERMINATION_STROBE |-> !term_strobe_odt)
        else $error("termination strobe on a non-byte device");

    a_strobe_no_drive: assert property (
        termination_strobe_on ##1 termination_strobe_on |-> (lane_pin_n_oe == '0))
        else $error("lane pin driven in strobe mode");

    a_strobe_no_rx: assert property (
        termination_strobe_on |=> !lane_rx_en)
        else $error("receiver on in strobe mode");

    a_rx_off_idle: assert property (
        !(wmask_on || winv_on) |=> !lane_rx_en)
        else $error("receiver on with no write function");

    a_read_pin_off: assert property (
        !rinv_on |=> (lane_pin_n_oe == '0))
        else $error("pin driven with read inversion off");

    a_strobe_term: assert property (
        term_strobe_odt == $past(termination_strobe_on && dqs_odt_en))
        else $error("strobe termination does not follow");

    a_mask_drop: assert property (
        pop_fire && wmask_on && lane_rx_en && !pop_if.data[DEV_W]
        |=> array_wr_valid && !array_wr_byte_en[0])
        else $error("masked lane written");

    a_wr_invert: assert property (
        pop_fire && winv_on && lane_rx_en && !pop_if.data[DEV_W]
        |=> array_wr_data[LW-1:0] == ~$past(pop_if.data[LW-1:0]))
        else $error("write inversion not applied");

    a_rd_invert: assert property (
        rd_valid && rinv_on && many_zeros(rd_data[LW-1:0])
        |=> !lane_pin_n_out[0] && lane_pin_n_oe[0] ##0
            dq_out[LW-1:0] == ~$past(rd_data[LW-1:0]))
        else $error("read inversion not applied");

    a_rd_plain: assert property (
        rd_valid && !many_zeros(rd_data[LW-1:0])
        |=> lane_pin_n_out[0] && dq_out[LW-1:0] == $past(rd_data[LW-1:0]))
        else $error("read data changed without inversion");

    a_lane_split: assert property (
        pop_fire && wmask_on && lane_rx_en
        && (pop_if.data[FW-1 -: LANES] == LOW_LANE_ONLY)
        |=> !array_wr_byte_en[0] && (array_wr_byte_en[LANES-1] || LANES == 1))
        else $error("lane mask leaked to other lane");

    c_masked_write: cover property (
        pop_fire && wmask_on && lane_rx_en && !pop_if.data[DEV_W]);
    c_inverted_write: cover property (
        pop_fire && winv_on && lane_rx_en && !pop_if.data[DEV_W]);
    c_inverted_read: cover property (
        rd_valid && rinv_on && many_zeros(rd_data[LW-1:0]));
    c_array_stall: cover property (
        array_wr_valid && !array_wr_ready ##1 array_wr_valid);
endmodule : dram_data_mask_inversion

// ---- verification/ctrl_model.sv ----
// memory controller model driving write words onto the lane pins
`timescale 1ns/100ps
module ctrl_model #(
    parameter int DEV_W = 16,
    parameter int LANES = 2
) (
    input  wire logic             link_clk,
    input  wire logic             wr_ready,
    output logic                  wr_strobe,
    output logic [DEV_W-1:0]      dq_in,
    output logic [LANES-1:0]      lane_pin_n_in
);
    // ------------------------------------------------------------
    // idle bus: lines terminated to the supply float high
    // ------------------------------------------------------------
    initial begin
        wr_strobe     = 1'b0;
        dq_in         = '1;
        lane_pin_n_in = '1;
    end

    // present one word just after a link edge, hold it until an edge sees wr_ready high
    // gives up after 200 edges; the edge count goes back to the caller
    task automatic send(input logic [DEV_W-1:0] d, input logic [LANES-1:0] p, output int n);
        n = 0;
        wr_strobe     <= 1'b1;
        dq_in         <= d;
        lane_pin_n_in <= p;
        do begin
            @(posedge link_clk);
            n++;
        end while (wr_ready !== 1'b1 && n < 200);
    endtask : send

    // release the bus after the last word of a burst
    task automatic idle();
        wr_strobe     <= 1'b0;
        dq_in         <= '1;
        lane_pin_n_in <= '1;
    endtask : idle
endmodule : ctrl_model

// ---- verification/tb_top.sv ----
// self-checking bench for the lane masking and inversion logic, x16 build
`timescale 1ns/100ps
module tb_top;
    import dmi_pkg::*;
    localparam int DW = 16;
    localparam int LN = 2;
    typedef struct {logic [DW-1:0] d; logic [LN-1:0] be;} wexp_t;

    logic            ref_clk, srst, link_clk, dqs_odt_en, wr_strobe, wr_ready;
    logic            array_wr_ready, array_wr_valid, rd_valid, dq_oe, lane_rx_en, term_strobe_odt;
    logic [MR_W-1:0] mr1, mr5;
    logic [DW-1:0]   dq_in, array_wr_data, rd_data, dq_out, p_d, ed;
    logic [LN-1:0]   pin_in, be, pin_out, pin_oe, ep;
    logic [31:0]     seed;
    int              err_total, checked;
    logic            stall, run_rd, p_ok, p_v, p_rinv, cur_wm, cur_wi;
    wexp_t           wq[$];
    logic            p_t, p_odt, odt8, oe8, pin8, rx8, e8;
    logic [7:0]      dq8;

    // ------------------------------------------------------------
    // clocks, unrelated in phase
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #40 link_clk = ~link_clk;
    end

    dram_data_mask_inversion #(.DEV_W(DW), .DEPTH(FIFO_DEPTH)) u_dram_data_mask_inversion (
        .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .mode_register_one(mr1),
        .mode_register_five(mr5), .dqs_odt_en(dqs_odt_en), .wr_strobe(wr_strobe), .dq_in(dq_in),
        .lane_pin_n_in(pin_in), .wr_ready(wr_ready), .array_wr_ready(array_wr_ready),
        .array_wr_valid(array_wr_valid), .array_wr_data(array_wr_data), .array_wr_byte_en(be),
        .rd_valid(rd_valid), .rd_data(rd_data), .dq_out(dq_out), .dq_oe(dq_oe),
        .lane_pin_n_out(pin_out), .lane_pin_n_oe(pin_oe), .lane_rx_en(lane_rx_en),
        .term_strobe_odt(term_strobe_odt));

    ctrl_model #(.DEV_W(DW), .LANES(LN)) u_ctrl_model (
        .link_clk(link_clk), .wr_ready(wr_ready), .wr_strobe(wr_strobe), .dq_in(dq_in),
        .lane_pin_n_in(pin_in));

    // byte-wide build on the same mode and read stimulus, for the strobe mode
    dram_data_mask_inversion #(.DEV_W(8), .DEPTH(FIFO_DEPTH)) u_dram_data_mask_inversion_x8 (
        .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .mode_register_one(mr1),
        .mode_register_five(mr5), .dqs_odt_en(dqs_odt_en), .wr_strobe(1'b0), .dq_in(8'hFF),
        .lane_pin_n_in(1'b1), .wr_ready(), .array_wr_ready(1'b1), .array_wr_valid(),
        .array_wr_data(), .array_wr_byte_en(), .rd_valid(rd_valid), .rd_data(rd_data[7:0]),
        .dq_out(dq8), .dq_oe(), .lane_pin_n_out(pin8), .lane_pin_n_oe(oe8), .lane_rx_en(rx8),
        .term_strobe_odt(odt8));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int zeros(input logic [7:0] b);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++) n += (b[i] == 1'b0);
        return n;
    endfunction : zeros

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // read stimulus and reference, array ready with random stalls
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        logic [31:0] r;
        if (run_rd && p_ok) begin
            for (int l = 0; l < LN; l++) begin
                ep[l] = !(p_rinv && zeros(p_d[l*8 +: 8]) > DBI_ZERO_LIMIT);
                ed[l*8 +: 8] = ep[l] ? p_d[l*8 +: 8] : ~p_d[l*8 +: 8];
            end
            check("dq_oe", {31'h0, p_v}, {31'h0, dq_oe});
            check("lane_pin_n_oe", {30'h0, {LN{p_rinv & p_v}}}, {30'h0, pin_oe});
            if (p_v) check("dq_out", {16'h0, ed}, {16'h0, dq_out});
            if (p_v && p_rinv) check("lane_pin_n_out", {30'h0, ep}, {30'h0, pin_out});
            e8 = !(p_rinv && !p_t && zeros(p_d[7:0]) > DBI_ZERO_LIMIT);
            check("x8 term_strobe_odt", {31'h0, p_t & p_odt}, {31'h0, odt8});
            check("x8 lane_pin_n_oe", {31'h0, p_v & p_rinv & ~p_t}, {31'h0, oe8});
            if (p_v) check("x8 dq_out", {24'h0, e8 ? p_d[7:0] : ~p_d[7:0]}, {24'h0, dq8});
            if (p_v && p_rinv && !p_t) check("x8 lane_pin_n_out", {31'h0, e8}, {31'h0, pin8});
        end
        p_ok   = run_rd;
        p_v    = rd_valid;
        p_d    = rd_data;
        p_rinv = mr5[MR5_RINV_BIT];
        p_t    = mr1[MR1_TERMINATION_STROBE_BIT];
        p_odt  = dqs_odt_en;
        r = rnd();
        rd_valid       <= r[0];
        rd_data        <= r[31:16];
        dqs_odt_en     <= r[5];
        array_wr_ready <= stall ? 1'b0 : r[3];
    end

    // write results leave in order; data of masked lanes is not compared
    always @(posedge ref_clk) begin
        wexp_t       e;
        logic [15:0] m;
        if (run_rd && array_wr_valid === 1'b1 && array_wr_ready === 1'b1) begin
            if (wq.size() == 0) begin
                check("unexpected write", 32'h0000_0000, 32'h0000_0001);
            end else begin
                e = wq.pop_front();
                m = {{8{e.be[1]}}, {8{e.be[0]}}};
                check("array_wr_byte_en", {30'h0, e.be}, {30'h0, be});
                check("array_wr_data", {16'h0, e.d & m}, {16'h0, array_wr_data & m});
            end
        end
    end

    // burst of random words, reference computed per lane from the active write mode
    task automatic burst(input int n);
        logic [31:0] r;
        wexp_t       e;
        int          w;
        @(posedge link_clk);
        for (int i = 0; i < n; i++) begin
            r = rnd();
            for (int l = 0; l < LN; l++) begin
                e.be[l] = cur_wm ? r[16+l] : 1'b1;
                e.d[l*8 +: 8] = (cur_wi && !r[16+l]) ? ~r[l*8 +: 8] : r[l*8 +: 8];
            end
            wq.push_back(e);
            u_ctrl_model.send(r[15:0], r[17:16], w);
            check("link accept", 32'h0000_0001, {31'h0, w < 200});
        end
        u_ctrl_model.idle();
    endtask : burst

    // ------------------------------------------------------------
    // main sequence: every write mode, read inversion on and off
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [MR_W-1:0] v;
        seed = 32'h0000_94B0;
        err_total = 0;
        checked = 0;
        srst = 1'b1;
        mr1 = 14'h0000;
        mr5 = 14'h0000;
        stall = 1'b0;
        run_rd = 1'b0;
        p_ok = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        dqs_odt_en = 1'b0;
        array_wr_ready = 1'b0;
        cur_wm = 1'b0;
        cur_wi = 1'b0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        run_rd <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            cur_wm = m[0];
            cur_wi = m[1] & ~m[0];
            @(posedge ref_clk);
            v = '0;
            v[MR5_WMASK_BIT] = cur_wm;
            v[MR5_WINV_BIT] = cur_wi;
            v[MR5_RINV_BIT] = m[2];
            mr5 <= v;
            mr1[MR1_TERMINATION_STROBE_BIT] <= m[1] & m[0];
            stall <= (m == 1);
            repeat (4) @(posedge ref_clk);
            check("lane_rx_en", {31'h0, cur_wm | cur_wi}, {31'h0, lane_rx_en});
            check("term_strobe_odt", 32'h0000_0000, {31'h0, term_strobe_odt});
            check("x8 lane_rx_en", {31'h0, (cur_wm | cur_wi) & ~(m[1] & m[0])}, {31'h0, rx8});
            fork
                burst(24);
                begin
                    n = 0;
                    while (stall && wr_ready !== 1'b0 && n < 3000) begin
                        @(posedge ref_clk);
                        n++;
                    end
                    if (stall) check("buffer full", 32'h0000_0000, {31'h0, wr_ready});
                    @(posedge ref_clk);
                    stall <= 1'b0;
                end
            join
            n = 0;
            while ((wq.size() != 0 || array_wr_valid !== 1'b0) && n < 1000) begin
                @(posedge ref_clk);
                n++;
            end
            check("words left", 32'h0000_0000, wq.size());
            $display("test mode %0d done", m);
        end
        conclude();
    end

    // watchdog cuts a hang short
    initial begin
        #400000;
        err_total++;
        $display("watchdog expired");
        conclude();
    end
endmodule : tb_top
